// File: hw/psc_regs.svh
// register offsets, field positions and counter indices for the
// port statistics counter bank; definitions only, included by bare name
// Summary of operation
// - index 0xF counts rx frames 65-127
// - 0x10-0x12 count rx 128-255, 256-511, 512-1023
// - 0x13 counts rx 1024 up to max
// - 0x14 sums good tx octets, pause included
// - 0x16 counts late collisions past 512 bits
// - 0x17 counts transmitted pause frames
// - 0x18-0x1A good tx bcast, mcast, ucast
// - 0x1B counts tx frames first deferred
// - 0x1C counts collisions, half duplex only
// - 0x1D counts excessive collision aborts
// - 0x1E counts success after one collision
// - 0x1F counts success after several collisions
// - writing 0x1C0E selects 0x0E, starts read
// - bit 31 flags overflow since last clear
// - a counter clears when read indirectly
// - word is overflow, valid, 30-bit count
// - counters reached only by indirect access
// - control bit 12 selects counter bank
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// host register map, 16-bit registers
`define PSC_ADDR_W 12
`define PSC_DATA_W 16
`define PSC_CTL_OFS 12'h4a0
`define PSC_DATA_LO_OFS 12'h4a8
`define PSC_DATA_HI_OFS 12'h4aa

// indirect access control fields
`define PSC_CTL_BANK_BIT 12
`define PSC_CTL_OP_HI 11
`define PSC_CTL_OP_LO 10
`define PSC_CTL_OP_READ 2'h3
`define PSC_CTL_ADDR_HI 9
`define PSC_CTL_RESET 16'h0000

// counter word layout
`define PSC_WORD_W 32
`define PSC_OVF_BIT 31
`define PSC_VALID_BIT 30
`define PSC_CNT_W 30

// counter indices
`define PSC_NUM_CNT 32
`define PSC_IDX_W 5
`define PSC_IDX_LO 5'h0f
`define PSC_IDX_RSVD 5'h15
`define PSC_IX_RX_65 5'h0f
`define PSC_IX_RX_128 5'h10
`define PSC_IX_RX_256 5'h11
`define PSC_IX_RX_512 5'h12
`define PSC_IX_RX_1024 5'h13
`define PSC_IX_TX_OCT 5'h14
`define PSC_IX_TX_LATE 5'h16
`define PSC_IX_TX_PAUSE 5'h17
`define PSC_IX_TX_BCAST 5'h18
`define PSC_IX_TX_MCAST 5'h19
`define PSC_IX_TX_UCAST 5'h1a
`define PSC_IX_TX_DEFER 5'h1b
`define PSC_IX_TX_COLL 5'h1c
`define PSC_IX_TX_EXCESS 5'h1d
`define PSC_IX_TX_ONE 5'h1e
`define PSC_IX_TX_MULTI 5'h1f

// frame length bounds in octets
`define PSC_LEN_W 11
`define PSC_LEN_65 11'h041
`define PSC_LEN_127 11'h07f
`define PSC_LEN_128 11'h080
`define PSC_LEN_255 11'h0ff
`define PSC_LEN_256 11'h100
`define PSC_LEN_511 11'h1ff
`define PSC_LEN_512 11'h200
`define PSC_LEN_1023 11'h3ff
`define PSC_LEN_1024 11'h400
`define PSC_LEN_MAX_STD 11'h5f2
`define PSC_LEN_MAX_BIG 11'h600

// collision count field
`define PSC_COLL_W 4
`define PSC_COLL_ONE 4'h1
`define PSC_COLL_TWO 4'h2

`endif

// File: hw/psc_pkg.sv
// types shared by the port statistics counter bank
// assumes psc_regs.svh supplies all numeric constants
package psc_pkg;

    // indirect read sequencer
    typedef enum logic {
        PSC_RD_IDLE,
        PSC_RD_CAPTURE
    } psc_rd_state_t;

    // destination class of a transmitted frame
    typedef enum logic [1:0] {
        PSC_CAST_UCAST,
        PSC_CAST_BCAST,
        PSC_CAST_MCAST
    } psc_cast_t;

endpackage

// File: hw/psc_inc_if.sv
// carries per-counter increment amounts from the event decoder
// to the counter cells; one slot per counter index
`timescale 1ns/1ps
`default_nettype none
interface psc_inc_if #(
    parameter int N = 32,
    parameter int W = 11
);
    logic [W-1:0] inc [N];

    modport src (output inc);
    modport dst (input inc);
endinterface
`default_nettype wire

// File: hw/psc_counter_cell.sv
// one read-clear statistics counter with sticky overflow
// assumes inc and clr are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module psc_counter_cell #(
    parameter int INC_W = 11
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [INC_W-1:0] inc,
    input wire logic clr,
    output logic ovf,
    output logic [`PSC_CNT_W-1:0] cnt
);
    logic [`PSC_CNT_W-1:0] cnt_q;
    logic ovf_q;
    logic [`PSC_CNT_W-1:0] base;
    logic [`PSC_CNT_W:0] sum;

    // a clear and an event in one cycle keep the event
    assign base = clr ? '0 : cnt_q;
    assign sum = {1'b0, base} + {{(`PSC_CNT_W + 1 - INC_W){1'b0}}, inc};

    // count wraps, carry sets the sticky flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= sum[`PSC_CNT_W-1:0];
            ovf_q <= (ovf_q & ~clr) | sum[`PSC_CNT_W];
        end
    end

    assign ovf = ovf_q;
    assign cnt = cnt_q;
endmodule // psc_counter_cell
`default_nettype wire

// File: hw/psc_event_decode.sv
// turns rx/tx status strobes into per-counter increment amounts
// assumes status inputs are single-cycle strobes with their fields
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module psc_event_decode (
    input wire logic rx_done,
    input wire logic [`PSC_LEN_W-1:0] rx_len,
    input wire logic max_len_big,
    input wire logic half_duplex,
    input wire logic tx_done,
    input wire logic tx_ok,
    input wire logic [`PSC_LEN_W-1:0] tx_octets,
    input wire logic tx_pause,
    input wire psc_pkg::psc_cast_t tx_cast,
    input wire logic tx_deferred,
    input wire logic [`PSC_COLL_W-1:0] tx_coll_cnt,
    input wire logic tx_coll,
    input wire logic tx_late_coll,
    input wire logic tx_excess,
    psc_inc_if.src inc_bus
);
    localparam int W = `PSC_LEN_W;

    // inclusive length window test
    function automatic logic in_range(input logic [W-1:0] len,
                                      input logic [W-1:0] lo,
                                      input logic [W-1:0] hi);
        in_range = (len >= lo) && (len <= hi);
    endfunction

    // widen a single event to an increment of one
    function automatic logic [W-1:0] one(input logic ev);
        one = {{(W-1){1'b0}}, ev};
    endfunction

    logic [W-1:0] rx_max;
    logic tx_good;
    logic tx_data_good;

    // upper bin limit follows the max packet size setting
    assign rx_max = max_len_big ? `PSC_LEN_MAX_BIG : `PSC_LEN_MAX_STD;
    assign tx_good = tx_done & tx_ok;
    assign tx_data_good = tx_good & ~tx_pause;

    // every slot driven; unused ones stay zero
    always_comb begin
        for (int i = 0; i < `PSC_NUM_CNT; i++) begin
            inc_bus.inc[i] = '0;
        end
        // receive length bins, bad frames included
        inc_bus.inc[`PSC_IX_RX_65] = one(rx_done &
            in_range(rx_len, `PSC_LEN_65, `PSC_LEN_127));
        inc_bus.inc[`PSC_IX_RX_128] = one(rx_done &
            in_range(rx_len, `PSC_LEN_128, `PSC_LEN_255));
        inc_bus.inc[`PSC_IX_RX_256] = one(rx_done &
            in_range(rx_len, `PSC_LEN_256, `PSC_LEN_511));
        inc_bus.inc[`PSC_IX_RX_512] = one(rx_done &
            in_range(rx_len, `PSC_LEN_512, `PSC_LEN_1023));
        inc_bus.inc[`PSC_IX_RX_1024] = one(rx_done &
            in_range(rx_len, `PSC_LEN_1024, rx_max));
        // transmit octets, pause frames included
        inc_bus.inc[`PSC_IX_TX_OCT] = tx_good ? tx_octets : '0;
        inc_bus.inc[`PSC_IX_TX_LATE] = one(tx_late_coll);
        inc_bus.inc[`PSC_IX_TX_PAUSE] = one(tx_good & tx_pause);
        // cast classes are one enum so never overlap
        inc_bus.inc[`PSC_IX_TX_BCAST] = one(tx_data_good &
            (tx_cast == psc_pkg::PSC_CAST_BCAST));
        inc_bus.inc[`PSC_IX_TX_MCAST] = one(tx_data_good &
            (tx_cast == psc_pkg::PSC_CAST_MCAST));
        inc_bus.inc[`PSC_IX_TX_UCAST] = one(tx_data_good &
            (tx_cast == psc_pkg::PSC_CAST_UCAST));
        inc_bus.inc[`PSC_IX_TX_DEFER] = one(tx_done & tx_deferred);
        inc_bus.inc[`PSC_IX_TX_COLL] = one(tx_coll & half_duplex);
        inc_bus.inc[`PSC_IX_TX_EXCESS] = one(tx_excess);
        inc_bus.inc[`PSC_IX_TX_ONE] = one(tx_good &
            (tx_coll_cnt == `PSC_COLL_ONE));
        inc_bus.inc[`PSC_IX_TX_MULTI] = one(tx_good &
            (tx_coll_cnt >= `PSC_COLL_TWO));
    end
endmodule // psc_event_decode
`default_nettype wire

// File: hw/psc_port_stats.sv
// port statistics counter bank with indirect read access
// assumes a synchronous 16-bit host register port on ref_clk and
// single-cycle status strobes from the mac datapath
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module psc_port_stats (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PSC_ADDR_W-1:0] reg_addr,
    input wire logic [`PSC_DATA_W-1:0] reg_wdata,
    output logic [`PSC_DATA_W-1:0] reg_rdata,
    output logic rd_busy,
    input wire logic rx_done,
    input wire logic [`PSC_LEN_W-1:0] rx_len,
    input wire logic max_len_big,
    input wire logic half_duplex,
    input wire logic tx_done,
    input wire logic tx_ok,
    input wire logic [`PSC_LEN_W-1:0] tx_octets,
    input wire logic tx_pause,
    input wire psc_pkg::psc_cast_t tx_cast,
    input wire logic tx_deferred,
    input wire logic [`PSC_COLL_W-1:0] tx_coll_cnt,
    input wire logic tx_coll,
    input wire logic tx_late_coll,
    input wire logic tx_excess
);
    localparam int N = `PSC_NUM_CNT;
    localparam int IW = `PSC_IDX_W;

    // read sequencer and host registers
    psc_pkg::psc_rd_state_t state_q;
    psc_pkg::psc_rd_state_t state_d;
    logic [`PSC_DATA_W-1:0] ctl_q;
    logic [`PSC_DATA_W-1:0] ctl_d;
    logic [`PSC_DATA_W-1:0] rdata_q;
    logic [`PSC_DATA_W-1:0] rdata_d;
    logic busy_q;
    logic busy_d;
    logic [IW-1:0] sel_q;
    logic [IW-1:0] sel_d;
    logic [`PSC_WORD_W-1:0] word_q;
    logic [`PSC_WORD_W-1:0] word_d;

    // per-index view of the counter cells
    wire [`PSC_CNT_W-1:0] cnt_arr [N];
    wire [N-1:0] ovf_vec;
    wire [N-1:0] clr_vec;

    // increment slots from the event decoder
    psc_inc_if #(
        .N(N),
        .W(`PSC_LEN_W)
    ) inc_bus ();

    // host access decode
    wire wr_ctl = reg_wr && (reg_addr == `PSC_CTL_OFS);
    wire rd_ctl = reg_rd && (reg_addr == `PSC_CTL_OFS);
    wire rd_hi = reg_rd && (reg_addr == `PSC_DATA_HI_OFS);
    wire rd_lo = reg_rd && (reg_addr == `PSC_DATA_LO_OFS);

    // a read command needs the bank bit and the read opcode
    wire op_read = reg_wdata[`PSC_CTL_OP_HI:`PSC_CTL_OP_LO] ==
        `PSC_CTL_OP_READ;
    wire bank_sel = reg_wdata[`PSC_CTL_BANK_BIT];
    wire launch = wr_ctl && bank_sel && op_read;

    // counter index from the low end of the address field;
    // counters have no address of their own on the host port
    wire [IW-1:0] new_idx = reg_wdata[IW-1:0];
    wire cap = (state_q == psc_pkg::PSC_RD_CAPTURE);

    // next values of the host registers
    assign ctl_d = wr_ctl ? reg_wdata : ctl_q;
    assign sel_d = launch ? new_idx : sel_q;

    // whole word taken in one step while the cell clears, so
    // both halves agree and an event in that cycle is kept;
    // the valid flag is set by every capture
    assign word_d = cap ? {ovf_vec[sel_q], 1'b1, cnt_arr[sel_q]} :
        word_q;

    // host read data, held between reads
    assign rdata_d = rd_hi ? word_q[`PSC_WORD_W-1:`PSC_DATA_W] :
        rd_lo ? word_q[`PSC_DATA_W-1:0] :
        rd_ctl ? ctl_q : rdata_q;

    // sequencer: one capture cycle per command
    always_comb begin
        state_d = state_q;
        busy_d = 1'b0;
        case (state_q)
            psc_pkg::PSC_RD_IDLE: begin
                if (launch) begin
                    state_d = psc_pkg::PSC_RD_CAPTURE;
                    busy_d = 1'b1;
                end
            end
            psc_pkg::PSC_RD_CAPTURE: begin
                // a new command here starts another capture
                if (launch) begin
                    busy_d = 1'b1;
                end else begin
                    state_d = psc_pkg::PSC_RD_IDLE;
                end
            end
            default: begin
                state_d = psc_pkg::PSC_RD_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= psc_pkg::PSC_RD_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
        end
    end

    // control register and selected index
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q <= `PSC_CTL_RESET;
            sel_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            sel_q <= sel_d;
        end
    end

    // captured word and host read data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word_q <= '0;
            rdata_q <= '0;
        end else begin
            word_q <= word_d;
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign rd_busy = busy_q;

    // event decoder fills one increment slot per index
    psc_event_decode u_decode (
        .rx_done(rx_done),
        .rx_len(rx_len),
        .max_len_big(max_len_big),
        .half_duplex(half_duplex),
        .tx_done(tx_done),
        .tx_ok(tx_ok),
        .tx_octets(tx_octets),
        .tx_pause(tx_pause),
        .tx_cast(tx_cast),
        .tx_deferred(tx_deferred),
        .tx_coll_cnt(tx_coll_cnt),
        .tx_coll(tx_coll),
        .tx_late_coll(tx_late_coll),
        .tx_excess(tx_excess),
        .inc_bus(inc_bus)
    );

    // clear strobe for the cell being captured
    for (genvar g = 0; g < N; g++) begin : g_clr
        assign clr_vec[g] = cap && (sel_q == IW'(g));
    end

    // lower indices live outside this bank and the reserved
    // slot has no cell; all of them give a zero count and a clear overflow bit
    for (genvar g = 0; g < N; g++) begin : g_absent
        if (g < `PSC_IDX_LO || g == `PSC_IDX_RSVD) begin : g_zero
            assign cnt_arr[g] = '0;
            assign ovf_vec[g] = 1'b0;
        end
    end

    // 65 to 127 octet receive bin
    psc_counter_cell u_rx_65 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_RX_65]),
        .clr(clr_vec[`PSC_IX_RX_65]),
        .ovf(ovf_vec[`PSC_IX_RX_65]),
        .cnt(cnt_arr[`PSC_IX_RX_65])
    );

    // 128 to 255 octet receive bin
    psc_counter_cell u_rx_128 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_RX_128]),
        .clr(clr_vec[`PSC_IX_RX_128]),
        .ovf(ovf_vec[`PSC_IX_RX_128]),
        .cnt(cnt_arr[`PSC_IX_RX_128])
    );

    // 256 to 511 octet receive bin
    psc_counter_cell u_rx_256 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_RX_256]),
        .clr(clr_vec[`PSC_IX_RX_256]),
        .ovf(ovf_vec[`PSC_IX_RX_256]),
        .cnt(cnt_arr[`PSC_IX_RX_256])
    );

    // 512 to 1023 octet receive bin
    psc_counter_cell u_rx_512 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_RX_512]),
        .clr(clr_vec[`PSC_IX_RX_512]),
        .ovf(ovf_vec[`PSC_IX_RX_512]),
        .cnt(cnt_arr[`PSC_IX_RX_512])
    );

    // long receive bin up to the max length
    psc_counter_cell u_rx_1024 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_RX_1024]),
        .clr(clr_vec[`PSC_IX_RX_1024]),
        .ovf(ovf_vec[`PSC_IX_RX_1024]),
        .cnt(cnt_arr[`PSC_IX_RX_1024])
    );

    // good transmit octets
    psc_counter_cell u_tx_oct (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_OCT]),
        .clr(clr_vec[`PSC_IX_TX_OCT]),
        .ovf(ovf_vec[`PSC_IX_TX_OCT]),
        .cnt(cnt_arr[`PSC_IX_TX_OCT])
    );

    // late collisions
    psc_counter_cell u_tx_late (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_LATE]),
        .clr(clr_vec[`PSC_IX_TX_LATE]),
        .ovf(ovf_vec[`PSC_IX_TX_LATE]),
        .cnt(cnt_arr[`PSC_IX_TX_LATE])
    );

    // transmitted pause frames
    psc_counter_cell u_tx_pause (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_PAUSE]),
        .clr(clr_vec[`PSC_IX_TX_PAUSE]),
        .ovf(ovf_vec[`PSC_IX_TX_PAUSE]),
        .cnt(cnt_arr[`PSC_IX_TX_PAUSE])
    );

    // good broadcast frames
    psc_counter_cell u_tx_bcast (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_BCAST]),
        .clr(clr_vec[`PSC_IX_TX_BCAST]),
        .ovf(ovf_vec[`PSC_IX_TX_BCAST]),
        .cnt(cnt_arr[`PSC_IX_TX_BCAST])
    );

    // good multicast frames
    psc_counter_cell u_tx_mcast (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_MCAST]),
        .clr(clr_vec[`PSC_IX_TX_MCAST]),
        .ovf(ovf_vec[`PSC_IX_TX_MCAST]),
        .cnt(cnt_arr[`PSC_IX_TX_MCAST])
    );

    // good unicast frames
    psc_counter_cell u_tx_ucast (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_UCAST]),
        .clr(clr_vec[`PSC_IX_TX_UCAST]),
        .ovf(ovf_vec[`PSC_IX_TX_UCAST]),
        .cnt(cnt_arr[`PSC_IX_TX_UCAST])
    );

    // frames whose first attempt was deferred
    psc_counter_cell u_tx_defer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_DEFER]),
        .clr(clr_vec[`PSC_IX_TX_DEFER]),
        .ovf(ovf_vec[`PSC_IX_TX_DEFER]),
        .cnt(cnt_arr[`PSC_IX_TX_DEFER])
    );

    // all collisions in half duplex
    psc_counter_cell u_tx_coll (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_COLL]),
        .clr(clr_vec[`PSC_IX_TX_COLL]),
        .ovf(ovf_vec[`PSC_IX_TX_COLL]),
        .cnt(cnt_arr[`PSC_IX_TX_COLL])
    );

    // frames dropped at the collision limit
    psc_counter_cell u_tx_excess (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_EXCESS]),
        .clr(clr_vec[`PSC_IX_TX_EXCESS]),
        .ovf(ovf_vec[`PSC_IX_TX_EXCESS]),
        .cnt(cnt_arr[`PSC_IX_TX_EXCESS])
    );

    // sent after exactly one collision
    psc_counter_cell u_tx_one (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_ONE]),
        .clr(clr_vec[`PSC_IX_TX_ONE]),
        .ovf(ovf_vec[`PSC_IX_TX_ONE]),
        .cnt(cnt_arr[`PSC_IX_TX_ONE])
    );

    // sent after two or more collisions
    psc_counter_cell u_tx_multi (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(inc_bus.inc[`PSC_IX_TX_MULTI]),
        .clr(clr_vec[`PSC_IX_TX_MULTI]),
        .ovf(ovf_vec[`PSC_IX_TX_MULTI]),
        .cnt(cnt_arr[`PSC_IX_TX_MULTI])
    );
endmodule // psc_port_stats
`default_nettype wire

// File: testbench/psc_port_stats_monitor.sv
// concurrent checks on the host side of the statistics counter bank
// assumes one clock domain, ref_clk, with synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module psc_port_stats_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`PSC_ADDR_W-1:0] reg_addr,
    input wire logic [`PSC_DATA_W-1:0] reg_wdata,
    input wire logic [`PSC_DATA_W-1:0] reg_rdata,
    input wire logic rd_busy
);
    // read command on the control register, and a held high-half read
    wire launch = reg_wr && reg_addr == `PSC_CTL_OFS &&
        reg_wdata[`PSC_CTL_BANK_BIT] && reg_wdata[11:10] == 2'h3;
    wire hold_hi = reg_rd && reg_addr == `PSC_DATA_HI_OFS;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_busy_starts: assert property (launch |-> ##[0:2] rd_busy)
        else $error("read command did not start a capture");
    chk_busy_cause: assert property (rd_busy |-> launch ||
        $past(rd_busy) || $past(launch) || $past(launch, 2))
        else $error("capture started without a read command");
    chk_busy_bound: assert property ($rose(rd_busy) |-> ##[1:16] !rd_busy)
        else $error("capture did not finish");
    chk_reset_idle: assert property ($rose(rst_n) |-> !rd_busy)
        else $error("busy after reset");
    chk_fall_once: assert property ($fell(rd_busy) && !launch &&
        !$past(launch) |=> !rd_busy)
        else $error("capture repeated");
    chk_hi_stable: assert property (hold_hi && $past(hold_hi) &&
        $past(hold_hi, 2) && !rd_busy && !$past(rd_busy) |-> $stable(reg_rdata))
        else $error("high half changed while held");
    chk_hi_valid: assert property (hold_hi && $past(hold_hi) &&
        $past(hold_hi, 2) && !rd_busy && !$past(rd_busy) |-> reg_rdata[14])
        else $error("captured word not marked valid");
    chk_data_cause: assert property ($changed(reg_rdata) |-> reg_rd ||
        $past(reg_rd) || reg_wr || $past(reg_wr) || $past(rd_busy) ||
        $past(rd_busy, 2))
        else $error("read data moved with no access");
    cov_launch: cover property (launch);
    cov_done: cover property ($fell(rd_busy));
    cov_hi_read: cover property (hold_hi && reg_rdata[14]);
endmodule // psc_port_stats_monitor
bind psc_port_stats psc_port_stats_monitor mon (.ref_clk, .rst_n, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .rd_busy);
`default_nettype wire

// File: testbench/psc_port_stats_test.sv
// self-checking bench for the statistics counter bank
// assumes a 100 MHz ref_clk and a 3-cycle held host read
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module psc_port_stats_test;
    typedef struct packed {
        logic [1:0] k;
        logic [10:0] len;
        logic [5:0] f;
        logic [1:0] c;
        logic [3:0] cc;
        logic [4:0] ix;
        logic [15:0] n;
    } psc_row_t;
    logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_done = 0;
    logic max_len_big = 0, half_duplex = 0, tx_done = 0, tx_ok = 0;
    logic tx_pause = 0, tx_deferred = 0, tx_coll = 0, tx_late_coll = 0;
    logic tx_excess = 0, rd_busy;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [10:0] rx_len = 11'h000, tx_octets = 11'h000;
    logic [3:0] tx_coll_cnt = 4'h0;
    logic [31:0] w, e;
    psc_pkg::psc_cast_t tx_cast = psc_pkg::PSC_CAST_UCAST;
    int bad_count = 0, tests_run = 0;
    psc_row_t rw[];
    psc_port_stats uut (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .rd_busy, .rx_done, .rx_len, .max_len_big,
        .half_duplex, .tx_done, .tx_ok, .tx_octets, .tx_pause, .tx_cast,
        .tx_deferred, .tx_coll_cnt, .tx_coll, .tx_late_coll, .tx_excess);
    // row: kind, length, flags exc/defer/pause/ok/hd/big, cast, coll, index
    function automatic psc_row_t r(int k, l, f, c, cc, ix, n);
        return {2'(k), 11'(l), 6'(f), 2'(c), 4'(cc), 5'(ix), 16'(n)};
    endfunction
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rd_reg(logic [11:0] a, output logic [15:0] d);
        @(negedge ref_clk) {reg_rd, reg_addr} = {1'b1, a};
        repeat (3) @(posedge ref_clk);
        #1 d = reg_rdata;
        @(negedge ref_clk) reg_rd = 0;
    endtask
    // indirect read: command, wait for capture, high half then low half
    task automatic rd(int ix, output logic [31:0] word);
        logic [15:0] h, l;
        int t;
        @(negedge ref_clk) {reg_wr, reg_addr} = {1'b1, `PSC_CTL_OFS};
        reg_wdata = 16'h1c00 | 16'(ix);
        @(negedge ref_clk) reg_wr = 0;
        repeat (2) @(posedge ref_clk);
        for (t = 0; t < 20 && rd_busy !== 1'b0; t++) @(posedge ref_clk);
        rd_reg(`PSC_DATA_HI_OFS, h);
        for (t = 0; t < 8 && h[14] !== 1'b1; t++) rd_reg(`PSC_DATA_HI_OFS, h);
        rd_reg(`PSC_DATA_LO_OFS, l);
        word = {h, l};
    endtask
    task automatic clr(bit chk);
        for (int i = 15; i < 32; i++) if (i != 21) begin
            rd(i, w);
            if (chk) `CHK("reset word", 32'h4000_0000, w)
        end
    endtask
    task automatic ev(psc_row_t x);
        @(negedge ref_clk) {rx_done, tx_done} = {x.k == 0, x.k == 1};
        {tx_coll, tx_late_coll} = {x.k == 2, x.k == 3};
        {rx_len, tx_octets, tx_coll_cnt} = {x.len, x.len, x.cc};
        {tx_excess, tx_deferred, tx_pause, tx_ok, half_duplex, max_len_big} = x.f;
        tx_cast = psc_pkg::psc_cast_t'(x.c);
        @(negedge ref_clk) {rx_done, tx_done, tx_coll, tx_late_coll} = 4'h0;
        tx_excess = 1'b0;
    endtask
    // clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // watchdog
    initial begin
        #800000;
        bad_count++;
        complete_run;
    end
    // table rows, then read-clear and accumulation by hand
    initial begin
        rw = '{r(0, 65, 0, 0, 0, 15, 1), r(0, 127, 0, 0, 0, 15, 1),
            r(0, 64, 0, 0, 0, 15, 0), r(0, 128, 0, 0, 0, 16, 1),
            r(0, 255, 0, 0, 0, 16, 1), r(0, 256, 0, 0, 0, 17, 1),
            r(0, 511, 0, 0, 0, 17, 1), r(0, 512, 0, 0, 0, 18, 1),
            r(0, 1023, 0, 0, 0, 18, 1), r(0, 1024, 0, 0, 0, 19, 1),
            r(0, 1522, 0, 0, 0, 19, 1), r(0, 1523, 0, 0, 0, 19, 0),
            r(0, 1536, 1, 0, 0, 19, 1), r(1, 100, 4, 0, 0, 20, 100),
            r(1, 64, 12, 2, 0, 20, 64), r(1, 64, 12, 2, 0, 23, 1),
            r(1, 64, 4, 1, 0, 24, 1), r(1, 64, 4, 2, 0, 25, 1),
            r(1, 64, 0, 1, 0, 24, 0), r(1, 64, 4, 0, 0, 26, 1),
            r(1, 64, 20, 0, 0, 27, 1), r(1, 64, 32, 0, 0, 29, 1),
            r(1, 64, 4, 0, 1, 30, 1), r(1, 64, 4, 0, 2, 31, 1),
            r(1, 64, 4, 0, 1, 31, 0), r(2, 0, 2, 0, 0, 28, 1),
            r(2, 0, 0, 0, 0, 28, 0), r(3, 0, 0, 0, 0, 22, 1)};
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        clr(1);
        $display("reset values done");
        foreach (rw[i]) begin
            ev(rw[i]);
            rd(rw[i].ix, w);
            e = {2'b01, 30'(rw[i].n)};
            case (rw[i].k)
                2'h0: `CHK("rx word", e, w)
                2'h1: `CHK("tx word", e, w)
                default: `CHK("coll word", e, w)
            endcase
            clr(0);
            $display("row %0d done", i);
        end
        repeat (3) ev(r(3, 0, 0, 0, 0, 22, 3));
        rd(22, w);
        `CHK("late sum", 32'h4000_0003, w)
        rd(22, w);
        `CHK("after clear", 32'h4000_0000, w)
        $display("read clear done");
        complete_run;
    end
endmodule // psc_port_stats_test
`default_nettype wire
